// ### xdmpc_top.sv
// Purpose: Power control register, idle/wake logic and on-chip data-space decode.
// Assumes: MCU core on the same clock; register contents in the window live outside.
// Notes: Read data appear one cycle after a read strobe, with a valid pulse.
`timescale 1ns/1ps
`include "xdmpc_regs.svh"
module xdmpc_top
    import xdmpc_pkg::*;
#(
    parameter logic [15:0] WAKE_HOLD_CYCLES = 16'(`XDMPC_WAKE_HOLD_CYC)
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic [7:0] sfr_addr,
    input wire logic sfr_wr,
    input wire logic sfr_rd,
    input wire logic [7:0] sfr_wdata,
    output logic [7:0] sfr_rdata,
    output logic sfr_rvalid,
    output logic sfr_hit,
    input wire logic [15:0] xd_addr,
    input wire logic xd_wr,
    input wire logic xd_rd,
    input wire logic [7:0] xd_wdata,
    output logic [7:0] xd_rdata,
    output logic xd_rvalid,
    output logic xd_onchip,
    output xdmpc_region_type xd_region,
    output xdmpc_mmr_type mmr_sel,
    output logic mmr_wr,
    output logic mmr_rd,
    output logic [7:0] mmr_wdata,
    input wire logic [7:0] mmr_rdata,
    input wire logic ext_wake_pin,
    input wire logic [7:0] port2_in,
    input wire logic wake_from_port2,
    output logic idle_request_bit,
    output logic ram_low_power,
    output logic osc_stop,
    output logic pll_stop,
    output logic watchdog_suspend,
    output logic core_irq_block,
    output logic wake_irq,
    output logic baud_doubler_bit,
    output logic [1:0] general_flag_bits
);
    logic [1:0] rst_sync_q;
    logic rst_n;
    xdmpc_state_type st_q;
    xdmpc_state_type st_d;
    xdmpc_ram_if ram ();
    xdmpc_region_type region;
    xdmpc_mmr_type mmr_reg;
    logic ram_acc;
    logic wake_asserted;
    logic pwr_wr;
    logic idle_set;
    logic [7:0] pwr_value;

    // External data space from XDMPC_SPACE_START up split into on-chip regions; lower addresses stay RG_NONE
    function automatic xdmpc_region_type xdmpc_decode_region(input logic [15:0] a);
        xdmpc_region_type r;
        r = RG_NONE;
        if (a >= `XDMPC_MMR_START) begin
            r = RG_MMR;
        end else if (a >= `XDMPC_RSV2_START) begin
            r = RG_DESC_RSV;
        end else if (a >= `XDMPC_IN_DESC_START) begin
            r = RG_IN_DESC;
        end else if (a >= `XDMPC_RSV1_START) begin
            r = RG_DESC_RSV;
        end else if (a >= `XDMPC_OUT_DESC_START) begin
            r = RG_OUT_DESC;
        end else if (a >= `XDMPC_SETUP_START) begin
            r = RG_SETUP;
        end else if (a >= `XDMPC_EP0_IN_START) begin
            r = RG_EP0_IN;
        end else if (a >= `XDMPC_EP0_OUT_START) begin
            r = RG_EP0_OUT;
        end else if (a >= `XDMPC_SPACE_START) begin
            r = RG_BUFFER;
        end
        return r;
    endfunction

    // Register window decode; anything unlisted stays MR_NONE
    function automatic xdmpc_mmr_type xdmpc_decode_mmr(input logic [15:0] a);
        xdmpc_mmr_type m;
        m = MR_NONE;
        case (a)
            `XDMPC_EP0_IN_CFG: m = MR_EP0_IN_CFG;
            `XDMPC_EP0_IN_CNT: m = MR_EP0_IN_CNT;
            `XDMPC_EP0_OUT_CFG: m = MR_EP0_OUT_CFG;
            `XDMPC_EP0_OUT_CNT: m = MR_EP0_OUT_CNT;
            `XDMPC_IRQ_DELAY: m = MR_IRQ_DELAY;
            `XDMPC_MCU_CFG: m = MR_MCU_CFG;
            `XDMPC_VEC_IRQ: m = MR_VEC_IRQ;
            `XDMPC_WDOG: m = MR_WDOG;
            `XDMPC_PULLUP0: m = MR_PULLUP0;
            `XDMPC_PULLUP1: m = MR_PULLUP1;
            `XDMPC_PULLUP2: m = MR_PULLUP2;
            `XDMPC_PULLUP3: m = MR_PULLUP3;
            `XDMPC_TW_STAT: m = MR_TW_STAT;
            `XDMPC_TW_DOUT: m = MR_TW_DOUT;
            `XDMPC_TW_DIN: m = MR_TW_DIN;
            `XDMPC_TW_ADDR: m = MR_TW_ADDR;
            `XDMPC_ID_STAT: m = MR_ID_STAT;
            `XDMPC_USB_CTL: m = MR_USB_CTL;
            `XDMPC_USB_MASK: m = MR_USB_MASK;
            `XDMPC_USB_STAT: m = MR_USB_STAT;
            `XDMPC_FUNC_ADDR: m = MR_FUNC_ADDR;
            default: m = MR_NONE;
        endcase
        return m;
    endfunction

    // Reset is released in step with the clock
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            rst_sync_q <= 2'h0;
        end else begin
            rst_sync_q <= {rst_sync_q[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_q[1];

    xdmpc_ram u_ram (
        .clk(clk),
        .rst_n(rst_n),
        .port(ram.mem)
    );

    always_comb begin
        region = xdmpc_decode_region(xd_addr);
        mmr_reg = MR_NONE;
        if (region == RG_MMR) begin
            mmr_reg = xdmpc_decode_mmr(xd_addr);
        end
        // Reserved descriptor gaps are not backed by RAM accesses
        ram_acc = (region != RG_NONE) && (region != RG_MMR) && (region != RG_DESC_RSV);
        wake_asserted = wake_from_port2 ? (|st_q.p2_lvl) : st_q.pin_lvl;
        pwr_wr = sfr_wr && (sfr_addr == `XDMPC_PWR_ADDR);
        idle_set = pwr_wr && sfr_wdata[`XDMPC_PWR_IDLE_BIT];
        pwr_value = `XDMPC_PWR_RESET;
        pwr_value[`XDMPC_PWR_BAUD_BIT] = st_q.baud;
        pwr_value[`XDMPC_PWR_FLAG_HI:`XDMPC_PWR_FLAG_LO] = st_q.flags;
        pwr_value[`XDMPC_PWR_IDLE_BIT] = st_q.idle;
    end

    // RAM port: address offset from start of on-chip space
    always_comb begin
        ram.addr = 9'(xd_addr - `XDMPC_SPACE_START);
        ram.wr_en = xd_wr && ram_acc && !st_q.idle;
        ram.rd_en = xd_rd && ram_acc && !st_q.idle;
        ram.wr_data = xd_wdata;
    end

    always_comb begin
        st_d = st_q;
        st_d.wake_irq = 1'b0;
        st_d.xd_rvalid = 1'b0;
        st_d.sfr_rvalid = 1'b0;

        // Three-stage capture; level moves once stages two and three agree
        st_d.pin_sync = {st_q.pin_sync[1:0], ext_wake_pin};
        if (st_q.pin_sync[1] == st_q.pin_sync[2]) begin
            st_d.pin_lvl = st_q.pin_sync[2];
        end
        for (int i = 0; i < 8; i++) begin
            st_d.p2_sync[i] = {st_q.p2_sync[i][1:0], port2_in[i]};
            if (st_q.p2_sync[i][1] == st_q.p2_sync[i][2]) begin
                st_d.p2_lvl[i] = st_q.p2_sync[i][2];
            end
        end

        // Plain storage bits of the power register; reserved bits dropped
        if (pwr_wr) begin
            st_d.baud = sfr_wdata[`XDMPC_PWR_BAUD_BIT];
            st_d.flags = sfr_wdata[`XDMPC_PWR_FLAG_HI:`XDMPC_PWR_FLAG_LO];
        end

        // Idle and wake sequencing
        case (st_q.wk_state)
            WK_AWAKE: begin
                st_d.hold_cnt = 16'h0000;
                if (idle_set) begin
                    st_d.wk_state = WK_IDLE;
                end
            end
            WK_IDLE: begin
                if (wake_asserted) begin
                    st_d.wk_state = WK_HOLD;
                    st_d.hold_cnt = 16'h0001;
                end
            end
            WK_HOLD: begin
                if (!wake_asserted) begin
                    // Any gap restarts the hold measurement
                    st_d.wk_state = WK_IDLE;
                    st_d.hold_cnt = 16'h0000;
                end else if (st_q.hold_cnt >= WAKE_HOLD_CYCLES - 16'h0001) begin
                    st_d.wk_state = idle_set ? WK_IDLE : WK_AWAKE;
                    st_d.hold_cnt = 16'h0000;
                    st_d.wake_irq = 1'b1;
                end else begin
                    st_d.hold_cnt = st_q.hold_cnt + 16'h0001;
                end
            end
            default: begin
                st_d.wk_state = WK_AWAKE;
                st_d.hold_cnt = 16'h0000;
            end
        endcase
        st_d.idle = (st_d.wk_state != WK_AWAKE);

        // Special-function read of the power register
        if (sfr_rd) begin
            st_d.sfr_rvalid = 1'b1;
            st_d.sfr_rdata = (sfr_addr == `XDMPC_PWR_ADDR) ? pwr_value : 8'h00;
        end

        // Data-space read: RAM, listed register or zero
        if (xd_rd) begin
            st_d.xd_rvalid = 1'b1;
            st_d.rd_from_ram = ram_acc && !st_q.idle;
            st_d.mmr_rdata = (mmr_reg != MR_NONE) ? mmr_rdata : 8'h00;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_q <= '0;
            st_q.wk_state <= WK_AWAKE;
        end else begin
            st_q <= st_d;
        end
    end

    assign sfr_rdata = st_q.sfr_rdata;
    assign sfr_rvalid = st_q.sfr_rvalid;
    assign sfr_hit = (sfr_addr == `XDMPC_PWR_ADDR);
    assign xd_rdata = st_q.rd_from_ram ? ram.rd_data : st_q.mmr_rdata;
    assign xd_rvalid = st_q.xd_rvalid;
    assign xd_onchip = (region != RG_NONE);
    assign xd_region = region;
    assign mmr_sel = mmr_reg;
    assign mmr_wr = xd_wr && (mmr_reg != MR_NONE);
    assign mmr_rd = xd_rd && (mmr_reg != MR_NONE);
    assign mmr_wdata = xd_wdata;
    assign idle_request_bit = st_q.idle;
    assign ram_low_power = st_q.idle;
    assign osc_stop = st_q.idle;
    assign pll_stop = st_q.idle;
    assign watchdog_suspend = st_q.idle;
    assign core_irq_block = st_q.idle;
    assign wake_irq = st_q.wake_irq;
    assign baud_doubler_bit = st_q.baud;
    assign general_flag_bits = st_q.flags;
endmodule

// ### xdmpc_regs.svh
// Purpose: Offsets, field positions, reset values and timing counts.
// Assumes: Included by the top module's file by bare name.
// Notes: Offsets are byte addresses in their own space.
`ifndef XDMPC_REGS_SVH
`define XDMPC_REGS_SVH
`define XDMPC_PWR_ADDR 8'h87
`define XDMPC_PWR_RESET 8'h00
`define XDMPC_PWR_BAUD_BIT 7
`define XDMPC_PWR_FLAG_HI 3
`define XDMPC_PWR_FLAG_LO 2
`define XDMPC_PWR_IDLE_BIT 0
`define XDMPC_SPACE_START 16'hfd80
`define XDMPC_BUF_END 16'hfeef
`define XDMPC_EP0_OUT_START 16'hfef0
`define XDMPC_EP0_IN_START 16'hfef8
`define XDMPC_SETUP_START 16'hff00
`define XDMPC_OUT_DESC_START 16'hff08
`define XDMPC_RSV1_START 16'hff20
`define XDMPC_IN_DESC_START 16'hff48
`define XDMPC_RSV2_START 16'hff60
`define XDMPC_RAM_END 16'hff7f
`define XDMPC_MMR_START 16'hff80
`define XDMPC_EP0_IN_CFG 16'hff80
`define XDMPC_EP0_IN_CNT 16'hff81
`define XDMPC_EP0_OUT_CFG 16'hff82
`define XDMPC_EP0_OUT_CNT 16'hff83
`define XDMPC_IRQ_DELAY 16'hff84
`define XDMPC_MCU_CFG 16'hff90
`define XDMPC_VEC_IRQ 16'hff92
`define XDMPC_WDOG 16'hff93
`define XDMPC_PULLUP0 16'hff94
`define XDMPC_PULLUP1 16'hff95
`define XDMPC_PULLUP2 16'hff96
`define XDMPC_PULLUP3 16'hff97
`define XDMPC_TW_STAT 16'hfff0
`define XDMPC_TW_DOUT 16'hfff1
`define XDMPC_TW_DIN 16'hfff2
`define XDMPC_TW_ADDR 16'hfff3
`define XDMPC_ID_STAT 16'hfff6
`define XDMPC_USB_CTL 16'hfffc
`define XDMPC_USB_MASK 16'hfffd
`define XDMPC_USB_STAT 16'hfffe
`define XDMPC_FUNC_ADDR 16'hffff
`define XDMPC_CLK_MHZ 25
`define XDMPC_WAKE_HOLD_US 400
`define XDMPC_WAKE_HOLD_CYC (`XDMPC_WAKE_HOLD_US * `XDMPC_CLK_MHZ)
`endif

// ### xdmpc_pkg.sv
// Purpose: Types shared by the power-control and data-map design.
// Assumes: Constants live in xdmpc_regs.svh.
// Notes: State of the top and RAM modules is one packed struct each.
package xdmpc_pkg;
    typedef enum logic [3:0] {
        RG_NONE, RG_BUFFER, RG_EP0_OUT, RG_EP0_IN, RG_SETUP,
        RG_OUT_DESC, RG_IN_DESC, RG_DESC_RSV, RG_MMR
    } xdmpc_region_type;
    typedef enum logic [4:0] {
        MR_NONE, MR_EP0_IN_CFG, MR_EP0_IN_CNT, MR_EP0_OUT_CFG, MR_EP0_OUT_CNT,
        MR_IRQ_DELAY, MR_MCU_CFG, MR_VEC_IRQ, MR_WDOG, MR_PULLUP0, MR_PULLUP1,
        MR_PULLUP2, MR_PULLUP3, MR_TW_STAT, MR_TW_DOUT, MR_TW_DIN, MR_TW_ADDR,
        MR_ID_STAT, MR_USB_CTL, MR_USB_MASK, MR_USB_STAT, MR_FUNC_ADDR
    } xdmpc_mmr_type;
    typedef enum logic [2:0] {
        WK_AWAKE = 3'b001,
        WK_IDLE = 3'b010,
        WK_HOLD = 3'b100
    } xdmpc_wake_type;
    typedef struct packed {
        xdmpc_wake_type wk_state;
        logic [15:0] hold_cnt;
        logic idle;
        logic baud;
        logic [1:0] flags;
        logic wake_irq;
        logic [2:0] pin_sync;
        logic pin_lvl;
        logic [7:0][2:0] p2_sync;
        logic [7:0] p2_lvl;
        logic xd_rvalid;
        logic rd_from_ram;
        logic [7:0] mmr_rdata;
        logic sfr_rvalid;
        logic [7:0] sfr_rdata;
    } xdmpc_state_type;
    typedef struct packed {
        logic [511:0][7:0] mem;
        logic [7:0] rd_data;
    } xdmpc_ram_state_type;
endpackage

// ### xdmpc_ram_if.sv
// Purpose: Port bundle between the decoder and the buffer RAM.
// Assumes: One clock, owned by the modules.
// Notes: Read data come from a register one cycle after rd_en.
`timescale 1ns/1ps
interface xdmpc_ram_if;
    logic [8:0] addr;
    logic wr_en;
    logic rd_en;
    logic [7:0] wr_data;
    logic [7:0] rd_data;
    modport mem (input addr, input wr_en, input rd_en, input wr_data, output rd_data);
    modport user (output addr, output wr_en, output rd_en, output wr_data, input rd_data);
endinterface

// ### xdmpc_ram.sv
// Purpose: 512-byte buffer and descriptor RAM.
// Assumes: Synchronous write, registered read, read-before-write.
// Notes: Contents are not reset; only the read register is.
`timescale 1ns/1ps
module xdmpc_ram
    import xdmpc_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    xdmpc_ram_if.mem port
);
    xdmpc_ram_state_type st_q;
    xdmpc_ram_state_type st_d;

    always_comb begin
        st_d = st_q;
        if (port.rd_en) begin
            st_d.rd_data = st_q.mem[port.addr];
        end
        if (port.wr_en) begin
            st_d.mem[port.addr] = port.wr_data;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_q.rd_data <= 8'h00;
        end else begin
            st_q <= st_d;
        end
    end

    assign port.rd_data = st_q.rd_data;
endmodule

// ### xdmpc_chk.sv
// Purpose: Assertions on power register, idle and wake, and data-space decode.
// Assumes: Bound to xdmpc_top; one clock domain.
// Notes: run_q counts the latest high run of the selected raw wake source.
`timescale 1ns/1ps
module xdmpc_chk
    import xdmpc_pkg::*;
#(
    parameter logic [15:0] WAKE_HOLD_CYCLES = 16'h2710
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic [7:0] sfr_addr,
    input wire logic sfr_wr,
    input wire logic sfr_rd,
    input wire logic [7:0] sfr_wdata,
    input wire logic [7:0] sfr_rdata,
    input wire logic sfr_rvalid,
    input wire logic sfr_hit,
    input wire logic [15:0] xd_addr,
    input wire logic xd_wr,
    input wire logic xd_rd,
    input wire logic xd_rvalid,
    input wire logic xd_onchip,
    input wire xdmpc_region_type xd_region,
    input wire logic mmr_wr,
    input wire logic ext_wake_pin,
    input wire logic [7:0] port2_in,
    input wire logic wake_from_port2,
    input wire logic idle_request_bit,
    input wire logic ram_low_power,
    input wire logic osc_stop,
    input wire logic watchdog_suspend,
    input wire logic wake_irq,
    input wire logic baud_doubler_bit,
    input wire logic [1:0] general_flag_bits
);
    logic src;
    logic src_q;
    logic [15:0] run_q;
    logic [7:0] wd_q;
    assign src = wake_from_port2 ? |port2_in : ext_wake_pin;
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            src_q <= 1'b0;
            run_q <= 16'h0000;
            wd_q <= 8'h00;
        end else begin
            src_q <= src;
            wd_q <= sfr_wdata;
            if (src && !src_q) begin
                run_q <= 16'h0001;
            end else if (src && run_q != 16'hffff) begin
                run_q <= run_q + 16'h0001;
            end
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);
    property p_hit; sfr_hit == (sfr_addr == 8'h87); endproperty
    a_hit: assert property (p_hit) else $error("power register decode wrong");
    property p_rsv; sfr_rd && sfr_hit |=> sfr_rvalid && sfr_rdata[6:4] == 3'h0 && !sfr_rdata[1]; endproperty
    a_rsv: assert property (p_rsv) else $error("power register read bad");
    property p_idle_set; sfr_wr && sfr_hit && sfr_wdata[0] |=> idle_request_bit; endproperty
    a_idle_set: assert property (p_idle_set) else $error("idle not set");
    property p_idle_clr; $fell(idle_request_bit) |-> wake_irq && run_q >= WAKE_HOLD_CYCLES; endproperty
    a_idle_clr: assert property (p_idle_clr) else $error("idle cleared early");
    property p_sleep; ram_low_power == idle_request_bit && osc_stop == idle_request_bit
        && watchdog_suspend == idle_request_bit; endproperty
    a_sleep: assert property (p_sleep) else $error("sleep controls differ from idle");
    property p_fields; sfr_wr && sfr_hit |=> {baud_doubler_bit, general_flag_bits} == {wd_q[7], wd_q[3:2]};
    endproperty
    a_fields: assert property (p_fields) else $error("power fields not written");
    property p_onchip; xd_onchip == (xd_addr >= 16'hfd80); endproperty
    a_onchip: assert property (p_onchip) else $error("on-chip decode wrong");
    property p_mmr; xd_addr >= 16'hff80 |-> xd_region == RG_MMR; endproperty
    a_mmr: assert property (p_mmr) else $error("window decode wrong");
    property p_xrv; xd_rd |=> xd_rvalid; endproperty
    a_xrv: assert property (p_xrv) else $error("data read valid missing");
    property p_rsvw; xd_wr && (xd_addr == 16'hff91 || xd_addr == 16'hfff4) |-> !mmr_wr; endproperty
    a_rsvw: assert property (p_rsvw) else $error("reserved window write passed");
    c_wake: cover property (wake_irq);
    c_sfr: cover property (sfr_rd && sfr_hit);
    c_win: cover property (xd_rd && xd_region == RG_MMR);
endmodule
bind xdmpc_top xdmpc_chk #(.WAKE_HOLD_CYCLES(WAKE_HOLD_CYCLES)) chk_u (.*);

// ### xdmpc_mmr_model.sv
// Purpose: Stand-in for the window registers outside the decoder.
// Assumes: Decoder samples read data in the read cycle.
// Notes: Unselected data changes every cycle so stale captures show.
`timescale 1ns/1ps
module xdmpc_mmr_model
    import xdmpc_pkg::*;
(
    input wire logic clk,
    input wire xdmpc_mmr_type mmr_sel,
    input wire logic mmr_rd,
    output logic [7:0] mmr_rdata
);
    logic [7:0] junk_q = 8'h3c;
    always @(posedge clk) begin
        junk_q <= ~junk_q + 8'h35;
    end
    assign mmr_rdata = mmr_rd ? {3'h5, mmr_sel} : junk_q;
endmodule

// ### tb_external_data_space_map_power_control.sv
// Purpose: Self-checking bench for the power register and data-space decode.
// Assumes: Wake hold shortened to 16 cycles.
// Notes: Inputs change 1 ns after the rising edge.
`timescale 1ns/1ps
module tb_external_data_space_map_power_control;
    import xdmpc_pkg::*;
    localparam logic [15:0] HOLD = 16'h0010;
    logic clk = 1'b0;
    logic reset_n = 1'b0;
    logic sfr_wr = 1'b0, sfr_rd = 1'b0, xd_wr = 1'b0, xd_rd = 1'b0;
    logic ext_wake_pin = 1'b0, wake_from_port2 = 1'b0;
    logic [7:0] sfr_addr = 8'h00, sfr_wdata = 8'h00, xd_wdata = 8'h00, port2_in = 8'h00;
    logic [15:0] xd_addr = 16'h0000;
    logic [7:0] sfr_rdata, xd_rdata, mmr_wdata, mmr_rdata;
    logic sfr_rvalid, sfr_hit, xd_rvalid, xd_onchip, mmr_wr, mmr_rd, idle_request_bit;
    logic ram_low_power, osc_stop, pll_stop, watchdog_suspend, core_irq_block, wake_irq;
    logic baud_doubler_bit;
    logic [1:0] general_flag_bits;
    xdmpc_region_type xd_region;
    xdmpc_mmr_type mmr_sel;
    int num_errors = 0;
    int samples_checked = 0;
    xdmpc_top #(.WAKE_HOLD_CYCLES(HOLD)) dut_u (.*);
    xdmpc_mmr_model mdl_u (.*);
    always #20 clk = ~clk;
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            num_errors++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic tick();
        @(posedge clk);
        #1;
    endtask
    task automatic sfr_w(input logic [7:0] a, input logic [7:0] d);
        sfr_addr = a;
        sfr_wdata = d;
        sfr_wr = 1'b1;
        tick();
        sfr_wr = 1'b0;
        tick();
    endtask
    task automatic sfr_chk(input logic [7:0] a, input logic [7:0] exp);
        sfr_addr = a;
        sfr_rd = 1'b1;
        tick();
        sfr_rd = 1'b0;
        chk("sfr_hit_rvalid", {sfr_hit, sfr_rvalid}, {a == 8'h87, 1'b1});
        chk("sfr_rdata", sfr_rdata, exp);
        tick();
    endtask
    task automatic xd_w(input logic [15:0] a, input logic [7:0] d);
        xd_addr = a;
        xd_wdata = d;
        xd_wr = 1'b1;
        tick();
        xd_wr = 1'b0;
        tick();
    endtask
    task automatic xd_chk(input logic [15:0] a, input logic [7:0] exp);
        xd_addr = a;
        xd_rd = 1'b1;
        tick();
        xd_rd = 1'b0;
        chk("xd_rvalid", xd_rvalid, 1'b1);
        chk("xd_rdata", xd_rdata, exp);
        tick();
    endtask
    task automatic t_power();
        sfr_chk(8'h87, 8'h00);
        sfr_w(8'h87, 8'hfe);
        sfr_chk(8'h87, 8'h8c);
        chk("fields", {baud_doubler_bit, general_flag_bits, idle_request_bit}, 4'he);
        sfr_w(8'h88, 8'hff);
        sfr_chk(8'h87, 8'h8c);
        sfr_chk(8'h88, 8'h00);
        sfr_w(8'h87, 8'h00);
        sfr_chk(8'h87, 8'h00);
    endtask
    task automatic t_ram();
        logic [15:0] wa [6] = '{16'hfd80, 16'hfeef, 16'hff07, 16'hff5f, 16'hff20, 16'hfd7f};
        logic [7:0] wd [6] = '{8'h5a, 8'ha5, 8'h3c, 8'hc3, 8'h99, 8'h11};
        logic [7:0] we [6] = '{8'h5a, 8'ha5, 8'h3c, 8'hc3, 8'h00, 8'h00};
        for (int i = 0; i < 6; i++) begin
            xd_w(wa[i], wd[i]);
        end
        for (int i = 0; i < 6; i++) begin
            xd_chk(wa[i], we[i]);
        end
    endtask
    task automatic t_map();
        logic [15:0] ra [18] = '{16'hfd7f, 16'hfd80, 16'hfeef, 16'hfef0, 16'hfef7, 16'hfef8, 16'hfeff,
            16'hff00, 16'hff07, 16'hff08, 16'hff1f, 16'hff20, 16'hff47, 16'hff48, 16'hff5f, 16'hff60,
            16'hff7f, 16'hff80};
        logic [3:0] rr [18] = '{4'h0, 4'h1, 4'h1, 4'h2, 4'h2, 4'h3, 4'h3, 4'h4, 4'h4, 4'h5, 4'h5, 4'h7,
            4'h7, 4'h6, 4'h6, 4'h7, 4'h7, 4'h8};
        logic [15:0] ma [21] = '{16'hff80, 16'hff81, 16'hff82, 16'hff83, 16'hff84, 16'hff90, 16'hff92,
            16'hff93, 16'hff94, 16'hff95, 16'hff96, 16'hff97, 16'hfff0, 16'hfff1, 16'hfff2, 16'hfff3,
            16'hfff6, 16'hfffc, 16'hfffd, 16'hfffe, 16'hffff};
        logic [15:0] na [7] = '{16'hff85, 16'hff8f, 16'hff91, 16'hfff4, 16'hfff5, 16'hfff7, 16'hfffb};
        for (int i = 0; i < 18; i++) begin
            xd_addr = ra[i];
            tick();
            chk("xd_region", {12'h000, xd_region}, {12'h000, rr[i]});
            chk("xd_onchip", xd_onchip, i > 0);
        end
        for (int i = 0; i < 21; i++) begin
            xd_addr = ma[i];
            xd_wdata = 8'h5a;
            xd_wr = 1'b1;
            tick();
            chk("mmr_sel", {11'h000, mmr_sel}, 16'(i + 1));
            chk("mmr_wr_wdata", {mmr_wr, mmr_wdata}, {1'b1, 8'h5a});
            xd_wr = 1'b0;
            xd_chk(ma[i], {3'h5, 5'(i + 1)});
        end
        for (int i = 0; i < 7; i++) begin
            xd_addr = na[i];
            xd_wr = 1'b1;
            tick();
            chk("mmr_sel_rsv", {mmr_wr, mmr_sel}, 16'h0000);
            xd_w(na[i], 8'hff);
            xd_chk(na[i], 8'h00);
        end
    endtask
    task automatic wake(input logic p2);
        int n;
        wake_from_port2 = p2;
        sfr_w(8'h87, 8'h01);
        ext_wake_pin = !p2;
        port2_in = p2 ? 8'h10 : 8'h00;
        for (n = 0; n < 200 && wake_irq !== 1'b1; n++) begin
            tick();
        end
        if (wake_irq !== 1'b1) begin
            num_errors++;
            end_of_test();
        end
        chk("wake_time", 16'(n >= HOLD && n <= HOLD + 8), 16'h0001);
        tick();
        chk("idle_after_wake", {idle_request_bit, wake_irq}, 2'b00);
        ext_wake_pin = 1'b0;
        port2_in = 8'h00;
        repeat (8) tick();
    endtask
    task automatic t_idle();
        sfr_w(8'h87, 8'h01);
        chk("sleep", {idle_request_bit, ram_low_power, osc_stop, pll_stop, watchdog_suspend, core_irq_block},
            6'h3f);
        sfr_w(8'h87, 8'h00);
        sfr_chk(8'h87, 8'h01);
        xd_w(16'hfd80, 8'h77);
        xd_chk(16'hfd80, 8'h00);
        ext_wake_pin = 1'b1;
        port2_in = 8'hff;
        repeat (8) tick();
        ext_wake_pin = 1'b0;
        repeat (24) tick();
        chk("idle_short_wake", idle_request_bit, 1'b1);
        wake(1'b0);
        xd_chk(16'hfd80, 8'h5a);
        wake(1'b1);
    endtask
    initial begin
        repeat (5) @(posedge clk);
        #1;
        reset_n = 1'b1;
        repeat (3) tick();
        t_power();
        t_ram();
        t_map();
        t_idle();
        end_of_test();
    end
endmodule
